/* File: rtl/fcr_config_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module fcr_config_regs #(
    parameter int ADDR_W = 24
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic sck,
    input wire logic [fcr_pkg::NV_W-1:0] nv_image,
    input wire logic nv_wr_valid,
    input wire logic [fcr_pkg::NV_W-1:0] nv_wr_data,
    input wire logic wk_wr_valid,
    input wire logic [fcr_pkg::WK_W-1:0] wk_wr_data,
    input wire logic dummy_start,
    input wire logic addr_load,
    input wire logic [ADDR_W-1:0] addr_start,
    input wire logic byte_adv,
    input wire logic data_line_zero_in,
    input wire logic data_line_three_n_in,
    output logic device_ready,
    output logic [fcr_pkg::NV_W-1:0] persistent_config,
    output logic [fcr_pkg::WK_W-1:0] working_config,
    output logic [fcr_pkg::DUMMY_W-1:0] dummy_cycles,
    output logic [fcr_pkg::DRV_W-1:0] drive_strength,
    output logic hold_enable,
    output logic hold_asserted,
    output logic four_line_protocol,
    output logic two_line_protocol,
    output logic xip_skip_instr,
    output logic [fcr_pkg::XIP_W-1:0] xip_mode,
    output logic [fcr_pkg::LINES_W-1:0] xip_addr_lines,
    output logic link_cfg_valid,
    output logic dummy_active,
    output logic dummy_done,
    output logic xip_entry,
    output logic [ADDR_W-1:0] read_addr
);
    import fcr_pkg::*;
    fcr_boot_t state_reg;
    logic [WK_W-1:0] boot_word, pub_word_reg, wk_hold_reg, lk_cfg_reg;
    logic pub_tgl_reg, pub_tgl_lk, pub_seen_reg, wk_tgl_reg, wk_tgl_sys, wk_seen_reg;
    logic wk_apply, hold_pin_n, first_dummy_reg, loading;
    logic [DUMMY_W-1:0] dummy_cnt_reg;
    logic [ADDR_W-1:0] next_addr;
    assign loading = clk_en && (state_reg == ST_LOAD);
    // Working image as power-on leaves it
    assign boot_word = {nv_image[NV_DUMMY_HI:NV_DUMMY_LO],
                        nv_image[NV_XIP_HI:NV_XIP_LO] == XIP_OFF,
                        1'b0, WRAP_SEQ};
    assign wk_apply = clk_en && (wk_tgl_sys != wk_seen_reg);
    // ------------------------------------------------------------
    // Power-on sequence
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_RESET;
            device_ready <= 1'b0;
        end
        else if (clk_en)
        begin
            case (state_reg)
                ST_RESET: state_reg <= ST_LOAD;
                ST_LOAD: state_reg <= ST_RUN;
                ST_RUN: state_reg <= ST_RUN;
                default: state_reg <= ST_RESET;
            endcase
            device_ready <= (state_reg != ST_RESET);
        end
    end
    // Non-volatile image; a write changes only this copy, and the next power-on reloads it from nv_image
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            persistent_config <= NV_FACTORY;
        else if (loading)
            persistent_config <= nv_image;
        else if (clk_en && device_ready && nv_wr_valid)
            persistent_config <= nv_wr_data;
    end
    // ------------------------------------------------------------
    // Fields fixed at power-on, all but xip_skip_instr
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drive_strength <= NV_FACTORY[NV_DRV_HI:NV_DRV_LO];
            hold_enable <= NV_FACTORY[NV_HOLD_BIT];
            four_line_protocol <= 1'b0;
            two_line_protocol <= 1'b0;
        end
        else if (loading)
        begin
            drive_strength <= nv_image[NV_DRV_HI:NV_DRV_LO];
            hold_enable <= nv_image[NV_HOLD_BIT];
            four_line_protocol <= !nv_image[NV_QUAD_BIT];
            two_line_protocol <= !nv_image[NV_DUAL_BIT] && nv_image[NV_QUAD_BIT];
        end
    end
    // Working write clears the power-on xip_skip_instr; xip_mode and xip_addr_lines keep their power-on values
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            xip_mode <= XIP_OFF;
            xip_skip_instr <= 1'b0;
            xip_addr_lines <= LINES_NONE;
        end
        else if (loading)
        begin
            xip_mode <= nv_image[NV_XIP_HI:NV_XIP_LO];
            xip_skip_instr <= xip_lines(nv_image[NV_XIP_HI:NV_XIP_LO]) != LINES_NONE;
            xip_addr_lines <= xip_lines(nv_image[NV_XIP_HI:NV_XIP_LO]);
        end
        else if (wk_apply && device_ready)
            xip_skip_instr <= 1'b0;
    end
    // ------------------------------------------------------------
    // Working register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            working_config <= WK_RESET;
            dummy_cycles <= DUMMY_MAX;
        end
        else if (loading)
        begin
            working_config <= boot_word;
            dummy_cycles <= dummy_eff(nv_image[NV_DUMMY_HI:NV_DUMMY_LO]);
        end
        else if (wk_apply && device_ready)
        begin
            working_config <= wk_clean(wk_hold_reg);
            dummy_cycles <= dummy_eff(wk_hold_reg[WK_DUMMY_HI:WK_DUMMY_LO]);
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            wk_seen_reg <= 1'b0;
        else if (clk_en)
            wk_seen_reg <= wk_tgl_sys;
    end
    // Boot image handed to the link side once
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pub_word_reg <= WK_RESET;
            pub_tgl_reg <= 1'b0;
        end
        else if (loading)
        begin
            pub_word_reg <= boot_word;
            pub_tgl_reg <= !pub_tgl_reg;
        end
    end
    // ------------------------------------------------------------
    // Hold/reset pin
    // ------------------------------------------------------------
    fcr_sync #(.RESET_VAL(1'b1)) u_hold_sync (.clk(clk_sys), .rst_n(rst_n), .en(clk_en),
        .din(data_line_three_n_in), .dout(hold_pin_n));
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            hold_asserted <= 1'b0;
        else if (clk_en)
            hold_asserted <= hold_enable && !hold_pin_n;
    end
    // ------------------------------------------------------------
    // Link domain crossings
    // ------------------------------------------------------------
    fcr_sync u_wk_sync (.clk(clk_sys), .rst_n(rst_n), .en(clk_en), .din(wk_tgl_reg),
        .dout(wk_tgl_sys));
    // Serial clock stops between frames, so the boot image lands
    // only after five serial edges
    fcr_sync u_pub_sync (.clk(sck), .rst_n(rst_n), .en(1'b1), .din(pub_tgl_reg),
        .dout(pub_tgl_lk));
    // Hold stays stable until the next link-side write; nothing waits for the system side to take it
    always_ff @(posedge sck or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wk_hold_reg <= WK_RESET;
            wk_tgl_reg <= 1'b0;
        end
        else if (wk_wr_valid)
        begin
            wk_hold_reg <= wk_wr_data;
            wk_tgl_reg <= !wk_tgl_reg;
        end
    end
    // Link copy updates at once on a write
    always_ff @(posedge sck or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lk_cfg_reg <= WK_RESET;
            link_cfg_valid <= 1'b0;
            pub_seen_reg <= 1'b0;
        end
        else
        begin
            pub_seen_reg <= pub_tgl_lk;
            if (wk_wr_valid)
            begin
                lk_cfg_reg <= wk_clean(wk_wr_data);
                link_cfg_valid <= 1'b1;
            end
            else if (pub_tgl_lk != pub_seen_reg)
            begin
                lk_cfg_reg <= pub_word_reg;
                link_cfg_valid <= 1'b1;
            end
        end
    end
    // ------------------------------------------------------------
    // Dummy clocks; no check that the count suits the clock rate
    // ------------------------------------------------------------
    always_ff @(posedge sck or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dummy_cnt_reg <= DUMMY_MAX;
            dummy_active <= 1'b0;
            dummy_done <= 1'b0;
            first_dummy_reg <= 1'b0;
        end
        else if (dummy_start)
        begin
            dummy_cnt_reg <= dummy_eff(lk_cfg_reg[WK_DUMMY_HI:WK_DUMMY_LO]);
            dummy_active <= 1'b1;
            dummy_done <= 1'b0;
            first_dummy_reg <= 1'b1;
        end
        else if (dummy_active)
        begin
            first_dummy_reg <= 1'b0;
            dummy_cnt_reg <= dummy_cnt_reg - DUMMY_ONE;
            if (dummy_cnt_reg == DUMMY_ONE)
            begin
                dummy_active <= 1'b0;
                dummy_done <= 1'b1;
            end
        end
        else
            dummy_done <= 1'b0;
    end
    // Low on the first dummy edge confirms entry
    always_ff @(posedge sck or negedge rst_n)
    begin
        if (!rst_n)
            xip_entry <= 1'b0;
        else if (wk_wr_valid && wk_wr_data[WK_XIP_BIT])
            xip_entry <= 1'b0;
        else if (dummy_active && first_dummy_reg && !lk_cfg_reg[WK_XIP_BIT])
            xip_entry <= !data_line_zero_in;
    end
    // ------------------------------------------------------------
    // Read address stepping
    // ------------------------------------------------------------
    fcr_wrap_addr #(.ADDR_W(ADDR_W)) u_wrap (.addr(read_addr),
        .wrap(fcr_wrap_t'(lk_cfg_reg[WK_WRAP_HI:WK_WRAP_LO])), .next_addr(next_addr));
    always_ff @(posedge sck or negedge rst_n)
    begin
        if (!rst_n)
            read_addr <= '0;
        else if (addr_load)
            read_addr <= addr_start;
        else if (byte_adv)
            read_addr <= next_addr;
    end
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [DUMMY_W-1:0] chk_len_reg, chk_exp_reg;
    always_ff @(posedge sck or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chk_len_reg <= '0;
            chk_exp_reg <= '0;
        end
        else if (dummy_start)
        begin
            chk_len_reg <= '0;
            chk_exp_reg <= dummy_eff(lk_cfg_reg[WK_DUMMY_HI:WK_DUMMY_LO]);
        end
        else if (dummy_active)
            chk_len_reg <= chk_len_reg + DUMMY_ONE;
    end
    sequence s_load;
        clk_en && state_reg == ST_LOAD;
    endsequence
    boot_copy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_load |=> device_ready && persistent_config == $past(nv_image)
            && working_config == $past(boot_word))
        else $error("power-on copy missing");
    dummy_len_a: assert property (@(posedge sck) disable iff (!rst_n)
        dummy_done |-> chk_len_reg == chk_exp_reg && !dummy_active)
        else $error("dummy clock count wrong");
    zero_code_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        device_ready |-> dummy_cycles == dummy_eff(working_config[WK_DUMMY_HI:WK_DUMMY_LO]))
        else $error("dummy code decode wrong");
    quad_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_load |=> four_line_protocol == !$past(nv_image[NV_QUAD_BIT])
            && !(four_line_protocol && two_line_protocol))
        else $error("quad precedence lost");
    hold_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && !hold_enable |=> !hold_asserted)
        else $error("hold active while disabled");
    wrap_block_a: assert property (@(posedge sck) disable iff (!rst_n)
        byte_adv && !addr_load && lk_cfg_reg[WK_WRAP_HI:WK_WRAP_LO] != WRAP_SEQ
            |=> read_addr[ADDR_W-1:WRAP64_BITS] == $past(read_addr[ADDR_W-1:WRAP64_BITS]))
        else $error("wrap left its block");
    seq_step_a: assert property (@(posedge sck) disable iff (!rst_n)
        byte_adv && !addr_load && lk_cfg_reg[WK_WRAP_HI:WK_WRAP_LO] == WRAP_SEQ
            |=> read_addr == $past(read_addr) + ADDR_W'(1))
        else $error("sequential step wrong");
    wk_apply_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wk_apply && device_ready |=> working_config == wk_clean($past(wk_hold_reg)))
        else $error("working write not applied");
    xip_ignore_a: assert property (@(posedge sck) disable iff (!rst_n)
        dummy_active && first_dummy_reg && lk_cfg_reg[WK_XIP_BIT] && !wk_wr_valid
            |=> $stable(xip_entry))
        else $error("data line sampled while disarmed");
endmodule // fcr_config_regs
`default_nettype wire

/* File: rtl/fcr_pkg.sv */
// Notes on behaviour
// - Persistent upper nibble holds power-on dummy count
// - Dummy count 1..15, exactly that many clocks
// - Factory dummy default works at top clock
// - Too few dummies gives bad data, no flag
// - Persistent three-bit field picks power-on execute_in_place
// - In execute_in_place, skip instruction, take address
// - Persistent driver strength field, default thirty ohms
// - Persistent bit 4 enables hold/reset pin function
// - Zero disables hold/reset, one keeps it
// - Bit 3 zero selects four_line_protocol at power-on
// - Bit 2 zero selects two_line_protocol at power-on
// - Both zero: four_line_protocol wins
// - Working write replaces dummy and execute_in_place immediately
// - Working dummy code 0000 acts as 1111
// - Working bit 3 zero arms execute_in_place
// - Armed: sample data_line_zero on first dummy
// - Wrap codes 00/01/10 confine to 16/32/64 bytes
// - Wrap code 11 reads sequentially, no wrap
package fcr_pkg;
    localparam int NV_W = 16;
    localparam int WK_W = 8;
    localparam int DUMMY_W = 4;
    localparam int XIP_W = 3;
    localparam int DRV_W = 3;
    localparam int WRAP_W = 2;
    localparam int LINES_W = 3;
    localparam int SYNC_STAGES = 3;
    // ------------------------------------------------------------
    // Persistent register fields
    // ------------------------------------------------------------
    localparam int NV_DUMMY_HI = 15;
    localparam int NV_DUMMY_LO = 12;
    localparam int NV_XIP_HI = 11;
    localparam int NV_XIP_LO = 9;
    localparam int NV_DRV_HI = 8;
    localparam int NV_DRV_LO = 6;
    localparam int NV_HOLD_BIT = 4;
    localparam int NV_QUAD_BIT = 3;
    localparam int NV_DUAL_BIT = 2;
    localparam logic [NV_W-1:0] NV_FACTORY = 16'hFFFF;
    // ------------------------------------------------------------
    // Working register fields
    // ------------------------------------------------------------
    localparam int WK_DUMMY_HI = 7;
    localparam int WK_DUMMY_LO = 4;
    localparam int WK_XIP_BIT = 3;
    localparam int WK_RSVD_BIT = 2;
    localparam int WK_WRAP_HI = 1;
    localparam int WK_WRAP_LO = 0;
    localparam logic [WK_W-1:0] WK_RESET = 8'hFB;
    localparam logic [DUMMY_W-1:0] DUMMY_ZERO = 4'h0;
    localparam logic [DUMMY_W-1:0] DUMMY_ONE = 4'h1;
    localparam logic [DUMMY_W-1:0] DUMMY_MAX = 4'hF;
    localparam logic [LINES_W-1:0] LINES_ONE = 3'h1;
    localparam logic [LINES_W-1:0] LINES_TWO = 3'h2;
    localparam logic [LINES_W-1:0] LINES_FOUR = 3'h4;
    localparam logic [LINES_W-1:0] LINES_NONE = 3'h0;
    localparam int WRAP16_BITS = 4;
    localparam int WRAP32_BITS = 5;
    localparam int WRAP64_BITS = 6;

    typedef enum logic [XIP_W-1:0] {
        XIP_SINGLE = 3'h0,
        XIP_DUAL_OUT = 3'h1,
        XIP_DUAL_IO = 3'h2,
        XIP_QUAD_OUT = 3'h3,
        XIP_QUAD_IO = 3'h4,
        XIP_OFF = 3'h7
    } fcr_xip_t;

    typedef enum logic [WRAP_W-1:0] {
        WRAP_16 = 2'h0,
        WRAP_32 = 2'h1,
        WRAP_64 = 2'h2,
        WRAP_SEQ = 2'h3
    } fcr_wrap_t;

    typedef enum logic [1:0] {
        ST_RESET = 2'h0,
        ST_LOAD = 2'h1,
        ST_RUN = 2'h3
    } fcr_boot_t;

    function automatic logic [DUMMY_W-1:0] dummy_eff(input logic [DUMMY_W-1:0] code);
        dummy_eff = (code == DUMMY_ZERO) ? DUMMY_MAX : code;
    endfunction

    // Address lines in execute_in_place; reserved codes give none
    function automatic logic [LINES_W-1:0] xip_lines(input logic [XIP_W-1:0] mode);
        case (mode)
            XIP_SINGLE, XIP_DUAL_OUT, XIP_QUAD_OUT: xip_lines = LINES_ONE;
            XIP_DUAL_IO: xip_lines = LINES_TWO;
            XIP_QUAD_IO: xip_lines = LINES_FOUR;
            default: xip_lines = LINES_NONE;
        endcase
    endfunction

    function automatic logic [WK_W-1:0] wk_clean(input logic [WK_W-1:0] data);
        wk_clean = data & ~(WK_W'(1) << WK_RSVD_BIT);
    endfunction
endpackage

/* File: rtl/fcr_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module fcr_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic din,
    output logic dout
);
    import fcr_pkg::*;
    logic [SYNC_STAGES-1:0] stage_reg;

    // Output moves only when the last two stages agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage_reg <= {SYNC_STAGES{RESET_VAL}};
            dout <= RESET_VAL;
        end
        else if (en)
        begin
            stage_reg <= {stage_reg[SYNC_STAGES-2:0], din};
            if (stage_reg[SYNC_STAGES-1] == stage_reg[SYNC_STAGES-2])
                dout <= stage_reg[SYNC_STAGES-1];
        end
    end
endmodule // fcr_sync
`default_nettype wire

/* File: rtl/fcr_wrap_addr.sv */
`timescale 1ns/1ns
`default_nettype none
module fcr_wrap_addr #(
    parameter int ADDR_W = 24
) (
    input wire logic [ADDR_W-1:0] addr,
    input wire fcr_pkg::fcr_wrap_t wrap,
    output logic [ADDR_W-1:0] next_addr
);
    import fcr_pkg::*;
    logic [ADDR_W-1:0] incr;
    logic [ADDR_W-1:0] mask;

    always_comb
    begin
        incr = addr + ADDR_W'(1);
        case (wrap)
            WRAP_16: mask = (ADDR_W'(1) << WRAP16_BITS) - ADDR_W'(1);
            WRAP_32: mask = (ADDR_W'(1) << WRAP32_BITS) - ADDR_W'(1);
            WRAP_64: mask = (ADDR_W'(1) << WRAP64_BITS) - ADDR_W'(1);
            default: mask = '1;
        endcase
        // Aligned block keeps its upper bits; low bits roll over
        next_addr = (addr & ~mask) | (incr & mask);
    end
endmodule // fcr_wrap_addr
`default_nettype wire

/* File: testbench/fcr_config_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module fcr_config_regs_tb;
    import fcr_pkg::*;
    logic clk_sys, rst_n, clk_en, nv_wr_valid, data_line_three_n_in, sck, wk_wr_valid;
    logic dummy_start, addr_load, byte_adv, data_line_zero_in, device_ready, hold_enable;
    logic hold_asserted, four_line_protocol, two_line_protocol, xip_skip_instr;
    logic link_cfg_valid, dummy_active, dummy_done, xip_entry;
    logic [NV_W-1:0] nv_image, nv_wr_data, persistent_config;
    logic [WK_W-1:0] wk_wr_data, working_config;
    logic [23:0] addr_start, read_addr;
    logic [3:0] dummy_cycles, exp;
    logic [2:0] drive_strength, xip_mode, xip_addr_lines;
    logic [3:0] codes [4] = '{4'h0, 4'h1, 4'hF, 4'h2};
    logic [23:0] wraps [4] = '{24'h30, 24'h20, 24'h00, 24'h40};
    int miscompares = 0;
    int compares = 0;
    int cnt;

    fcr_config_regs i_fcr_config_regs (.clk_sys, .rst_n, .clk_en, .sck, .nv_image,
        .nv_wr_valid, .nv_wr_data, .wk_wr_valid, .wk_wr_data, .dummy_start, .addr_load,
        .addr_start, .byte_adv, .data_line_zero_in, .data_line_three_n_in, .device_ready,
        .persistent_config, .working_config, .dummy_cycles, .drive_strength, .hold_enable,
        .hold_asserted, .four_line_protocol, .two_line_protocol, .xip_skip_instr, .xip_mode,
        .xip_addr_lines, .link_cfg_valid, .dummy_active, .dummy_done, .xip_entry, .read_addr);
    fcr_host i_fcr_host (.sck, .wk_wr_valid, .wk_wr_data, .dummy_start, .addr_load,
        .addr_start, .byte_adv, .data_line_zero_in);

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial
    begin
        #1000000;
        miscompares++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        compares++;
        if (seen !== want)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic boot(input logic [NV_W-1:0] nv);
        int n;
        @(negedge clk_sys);
        rst_n = 1'b0;
        nv_image = nv;
        repeat (20) @(negedge clk_sys);
        check(persistent_config, 16'hFFFF);
        check(working_config, 8'hFB);
        check(drive_strength, 3'h7);
        check(xip_mode, 3'h7);
        check(link_cfg_valid, 1'b0);
        rst_n = 1'b1;
        n = 0;
        while (device_ready !== 1'b1 && n < 10)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 10)
        begin
            miscompares++;
            give_verdict();
        end
        i_fcr_host.idle(8);
        check(link_cfg_valid, 1'b1);
    endtask
    task automatic hold_probe(input logic want);
        data_line_three_n_in = 1'b0;
        repeat (6) @(negedge clk_sys);
        check(hold_asserted, want);
        data_line_three_n_in = 1'b1;
    endtask
    task automatic wr_wait(input logic [7:0] d);
        i_fcr_host.wr_wk(d);
        repeat (10) @(negedge clk_sys);
    endtask
    task automatic run_dummy(input logic l0);
        i_fcr_host.start_dummy(l0);
        cnt = 0;
        while (dummy_active === 1'b1 && cnt < 20)
        begin
            cnt++;
            i_fcr_host.tick();
            if (cnt == 1)
                i_fcr_host.flip_line();
        end
        if (cnt >= 20)
        begin
            miscompares++;
            give_verdict();
        end
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        nv_wr_valid = 1'b0;
        nv_wr_data = '0;
        data_line_three_n_in = 1'b1;
        nv_image = NV_FACTORY;
        boot(16'hFFFB);
        check(two_line_protocol, 1'b1);
        check(four_line_protocol, 1'b0);
        check(hold_enable, 1'b1);
        check(xip_skip_instr, 1'b0);
        check(dummy_cycles, 4'hF);
        hold_probe(1'b1);
        boot(16'h5963);
        check(persistent_config, 16'h5963);
        check(dummy_cycles, 4'h5);
        check(drive_strength, 3'h5);
        check(hold_enable, 1'b0);
        check({four_line_protocol, two_line_protocol}, 2'b10);
        check(xip_mode, 3'h4);
        check({xip_skip_instr, xip_addr_lines}, 4'hC);
        hold_probe(1'b0);
        clk_en = 1'b0;
        nv_wr_data = 16'hABCD;
        nv_wr_valid = 1'b1;
        @(negedge clk_sys);
        check(persistent_config, 16'h5963);
        clk_en = 1'b1;
        nv_wr_data = 16'h1234;
        @(negedge clk_sys);
        nv_wr_valid = 1'b0;
        @(negedge clk_sys);
        check(persistent_config, 16'h1234);
        check(dummy_cycles, 4'h5);
        foreach (codes[i])
        begin
            wr_wait({codes[i], 4'hF});
            exp = (codes[i] == 4'h0) ? 4'hF : codes[i];
            check(working_config, {codes[i], 4'hB});
            check(dummy_cycles, exp);
            check(xip_skip_instr, 1'b0);
            run_dummy(1'b1);
            check(cnt, exp);
            check(dummy_done, 1'b1);
        end
        wr_wait(8'h13);
        run_dummy(1'b0);
        check(xip_entry, 1'b1);
        wr_wait(8'h1B);
        check(xip_entry, 1'b0);
        foreach (wraps[w])
        begin
            wr_wait(8'h18 | 8'(w));
            i_fcr_host.load_addr(24'h00003F);
            check(read_addr, 24'h00003F);
            i_fcr_host.adv();
            check(read_addr, wraps[w]);
        end
        give_verdict();
    end
endmodule // fcr_config_regs_tb
`default_nettype wire

/* File: testbench/fcr_host.sv */
`timescale 1ns/1ns
`default_nettype none
module fcr_host (
    output logic sck,
    output logic wk_wr_valid,
    output logic [fcr_pkg::WK_W-1:0] wk_wr_data,
    output logic dummy_start,
    output logic addr_load,
    output logic [23:0] addr_start,
    output logic byte_adv,
    output logic data_line_zero_in
);
    initial
    begin
        {sck, wk_wr_valid, wk_wr_data, dummy_start, addr_load, addr_start, byte_adv} = '0;
        data_line_zero_in = 1'b1;
    end
    // Clock runs only inside frames
    task automatic tick();
        #3 sck = 1'b1;
        #3 sck = 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) tick();
    endtask
    // Caller picks a dummy count that suits the link rate
    task automatic wr_wk(input logic [7:0] d);
        wk_wr_data = d;
        wk_wr_valid = 1'b1;
        tick();
        wk_wr_valid = 1'b0;
        wk_wr_data = ~d;
        idle(2);
    endtask
    task automatic start_dummy(input logic l0);
        data_line_zero_in = l0;
        dummy_start = 1'b1;
        tick();
        dummy_start = 1'b0;
    endtask
    // Released line shows the inverse, not a stale level
    task automatic flip_line();
        data_line_zero_in = ~data_line_zero_in;
    endtask
    task automatic load_addr(input logic [23:0] a);
        addr_start = a;
        addr_load = 1'b1;
        tick();
        addr_load = 1'b0;
        addr_start = ~a;
    endtask
    task automatic adv();
        byte_adv = 1'b1;
        tick();
        byte_adv = 1'b0;
    endtask
endmodule // fcr_host
`default_nettype wire
